// *** pkg/dshpc_regs.vh ***
// Register map, reset values and timing constants of the hot-plug control.
`ifndef DSHPC_REGS_VH
`define DSHPC_REGS_VH

// Byte offsets on the AXI4-Lite register bus.
`define DSHPC_OFF_CTRL 8'h00
`define DSHPC_OFF_FAULT_TMO 8'h04
`define DSHPC_OFF_PG_DELAY 8'h08
`define DSHPC_OFF_STATUS 8'h0c

// Control register fields.
`define DSHPC_CTRL_AUTO_BIT 0
`define DSHPC_CTRL_RESET 32'h0000_0000

// Status register: one byte per slot, slot 0 in the low byte.
`define DSHPC_ST_MAIN_ON 0
`define DSHPC_ST_AUX_ON 1
`define DSHPC_ST_PGOOD 2
`define DSHPC_ST_MAIN_FLT 3
`define DSHPC_ST_ALL_FLT 4
`define DSHPC_ST_OT_PEND 5
`define DSHPC_ST_PRES_OK 6
`define DSHPC_ST_RST_DONE 7

// Bus responses.
`define DSHPC_RESP_OKAY 2'b00
`define DSHPC_RESP_SLVERR 2'b10

// Timing: clock rate and times in their own units.
`define DSHPC_CLK_MHZ 100
`define DSHPC_DEBOUNCE_US 4000
`define DSHPC_FAULT_TMO_US 11000
`define DSHPC_PG_DELAY_US 160000
`define DSHPC_CLEAR_PULSE_US 100

// Startup is twice the fault timeout, restart delay is 64 times it.
`define DSHPC_SU_SHIFT 1
`define DSHPC_RESTART_SHIFT 6

`endif

// *** design/dshpc_top.v ***
// Dual-slot hot-plug control logic with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "dshpc_regs.vh"

module dshpc_top #(
    parameter P_DEB_CYC = `DSHPC_DEBOUNCE_US * `DSHPC_CLK_MHZ,
    parameter P_TMO_CYC = `DSHPC_FAULT_TMO_US * `DSHPC_CLK_MHZ,
    parameter P_PGD_CYC = `DSHPC_PG_DELAY_US * `DSHPC_CLK_MHZ,
    parameter P_CLR_CYC = `DSHPC_CLEAR_PULSE_US * `DSHPC_CLK_MHZ
) (
    input wire i_clk_sys,
    input wire i_rst,
    // AXI4-Lite slave.
    input wire [7:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output wire o_s_axi_awready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output wire o_s_axi_wready,
    output wire [1:0] o_s_axi_bresp,
    output wire o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [7:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output wire o_s_axi_arready,
    output wire [31:0] o_s_axi_rdata,
    output wire [1:0] o_s_axi_rresp,
    output wire o_s_axi_rvalid,
    input wire i_s_axi_rready,
    // Shared supply lockout and temperature flags, high when cleared/hot.
    input wire i_uvlo_aux_ok,
    input wire i_uvlo_12_ok,
    input wire i_uvlo_33_ok,
    input wire i_overtemp,
    // Per-slot controls and sense flags, bit 0 is slot A.
    input wire [1:0] i_main_enable,
    input wire [1:0] i_aux_rail_enable,
    input wire [1:0] i_force_on_n,
    input wire [1:0] i_card_present_n,
    input wire [1:0] i_ilim_12,
    input wire [1:0] i_ilim_33,
    input wire [1:0] i_ilim_aux,
    input wire [1:0] i_pg_12,
    input wire [1:0] i_pg_33,
    input wire [1:0] i_pg_aux,
    input wire [1:0] i_switch_in,
    // Rail drives, open-drain status pins and the debounced switch outputs.
    output wire [1:0] o_gate_12_en,
    output wire [1:0] o_gate_33_en,
    output wire [1:0] o_aux_rail_output_en,
    output wire [1:0] o_fault_n_o,
    output wire [1:0] o_fault_n_oe,
    output wire [1:0] o_power_good_n_o,
    output wire [1:0] o_power_good_n_oe,
    output wire [1:0] o_switch_out
);

    function [31:0] strb_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer b;
        begin
            strb_merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    strb_merge[8*b +: 8] = data[8*b +: 8];
                end
            end
        end
    endfunction

    wire [25:0] async_in = {i_switch_in, i_pg_aux, i_pg_33, i_pg_12,
        i_ilim_aux, i_ilim_33, i_ilim_12, i_card_present_n, i_force_on_n,
        i_aux_rail_enable, i_main_enable, i_overtemp, i_uvlo_33_ok,
        i_uvlo_12_ok, i_uvlo_aux_ok};
    reg [25:0] sync1_r;
    reg [25:0] sync2_r;
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            // Active-low pins reset to their idle level, so the release of
            // reset never looks like a forced-on or freshly inserted slot.
            sync1_r <= 26'h0000f00;
            sync2_r <= 26'h0000f00;
        end else begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
        end
    end

    wire aux_ok = sync2_r[0];
    wire v12_ok = sync2_r[1];
    wire v33_ok = sync2_r[2];
    wire ot = sync2_r[3];
    wire main_uv_ok = aux_ok & v12_ok & v33_ok;

    // Register bus state.
    reg awready_r;
    reg wready_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg arready_r;
    reg rvalid_r;
    reg [1:0] rresp_r;
    reg [31:0] rdata_r;
    reg aw_have_r;
    reg w_have_r;
    reg [7:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg [31:0] ctrl_r;
    reg [31:0] tmo_r;
    reg [31:0] pgd_r;
    wire [15:0] status;
    wire auto_mode = ctrl_r[`DSHPC_CTRL_AUTO_BIT];
    wire [31:0] su_lim = tmo_r << `DSHPC_SU_SHIFT;
    wire [31:0] rst_lim = tmo_r << `DSHPC_RESTART_SHIFT;
    wire do_write = aw_have_r & w_have_r & ~bvalid_r;

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `DSHPC_RESP_OKAY;
            ctrl_r <= `DSHPC_CTRL_RESET;
            tmo_r <= P_TMO_CYC;
            pgd_r <= P_PGD_CYC;
        end else begin
            if (i_s_axi_awvalid & awready_r) begin
                awaddr_r <= i_s_axi_awaddr;
                aw_have_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (i_s_axi_wvalid & wready_r) begin
                wdata_r <= i_s_axi_wdata;
                wstrb_r <= i_s_axi_wstrb;
                w_have_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r <= `DSHPC_RESP_OKAY;
                case (awaddr_r)
                    `DSHPC_OFF_CTRL: begin
                        ctrl_r <= strb_merge(ctrl_r, wdata_r, wstrb_r)
                            & 32'h0000_0001;
                    end
                    `DSHPC_OFF_FAULT_TMO: begin
                        tmo_r <= strb_merge(tmo_r, wdata_r, wstrb_r);
                    end
                    `DSHPC_OFF_PG_DELAY: begin
                        pgd_r <= strb_merge(pgd_r, wdata_r, wstrb_r);
                    end
                    `DSHPC_OFF_STATUS: begin
                        bresp_r <= `DSHPC_RESP_OKAY;
                    end
                    default: begin
                        bresp_r <= `DSHPC_RESP_SLVERR;
                    end
                endcase
            end
            if (bvalid_r & i_s_axi_bready) begin
                bvalid_r <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= `DSHPC_RESP_OKAY;
            rdata_r <= 32'h0;
        end else if (i_s_axi_arvalid & arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= `DSHPC_RESP_OKAY;
            case (i_s_axi_araddr)
                `DSHPC_OFF_CTRL: rdata_r <= ctrl_r;
                `DSHPC_OFF_FAULT_TMO: rdata_r <= tmo_r;
                `DSHPC_OFF_PG_DELAY: rdata_r <= pgd_r;
                `DSHPC_OFF_STATUS: rdata_r <= {16'h0, status};
                default: begin
                    rdata_r <= 32'h0;
                    rresp_r <= `DSHPC_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r & i_s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1) begin : g_slot
            wire main_en = sync2_r[4 + s];
            wire aux_en = sync2_r[6 + s];
            wire force_on = ~sync2_r[8 + s];
            wire pres_n = sync2_r[10 + s];
            wire il_main = sync2_r[12 + s] | sync2_r[14 + s];
            wire il_aux = sync2_r[16 + s];
            wire all_good = sync2_r[18 + s] & sync2_r[20 + s]
                & sync2_r[22 + s];
            reg pres_ok_r;
            reg [31:0] pres_cnt_r;
            reg main_on_r;
            reg aux_on_r;
            reg [31:0] msu_r;
            reg [31:0] asu_r;
            reg [31:0] moc_r;
            reg [31:0] aoc_r;
            reg main_flt_r;
            reg all_flt_r;
            reg ot_pend_r;
            reg [31:0] rcnt_r;
            reg [31:0] mlow_r;
            reg [31:0] blow_r;
            reg mseen_r;
            reg bseen_r;
            reg [31:0] pg_cnt_r;
            reg pg_r;
            wire rdone = rcnt_r >= rst_lim;
            wire mtrip = main_on_r & il_main
                & (moc_r >= ((msu_r < su_lim) ? su_lim : tmo_r) - 32'h1);
            wire atrip = aux_on_r & il_aux
                & (aoc_r >= ((asu_r < su_lim) ? su_lim : tmo_r) - 32'h1);
            wire ot_done = ot_pend_r & ~ot;
            wire want_main = main_uv_ok & ~ot & ~main_flt_r & ~all_flt_r
                & ~mtrip & ~atrip & (force_on | (pres_ok_r & ~pres_n
                & main_en));
            wire want_aux = aux_ok & ~ot & ~all_flt_r & ~atrip
                & (force_on | (pres_ok_r & ~pres_n & aux_en));
            wire fault_set = mtrip | atrip | ot_done;

            always @(posedge i_clk_sys) begin
                if (i_rst) begin
                    pres_ok_r <= 1'b0;
                    pres_cnt_r <= 32'h0;
                    main_on_r <= 1'b0;
                    aux_on_r <= 1'b0;
                    msu_r <= 32'h0;
                    asu_r <= 32'h0;
                    moc_r <= 32'h0;
                    aoc_r <= 32'h0;
                    main_flt_r <= 1'b0;
                    all_flt_r <= 1'b0;
                    ot_pend_r <= 1'b0;
                    rcnt_r <= 32'h0;
                    mlow_r <= 32'h0;
                    blow_r <= 32'h0;
                    mseen_r <= 1'b0;
                    bseen_r <= 1'b0;
                    pg_cnt_r <= 32'h0;
                    pg_r <= 1'b0;
                end else begin
                    if (pres_n) begin
                        pres_cnt_r <= 32'h0;
                        pres_ok_r <= 1'b0;
                    end else if (pres_cnt_r >= P_DEB_CYC - 1) begin
                        pres_ok_r <= 1'b1;
                    end else begin
                        pres_cnt_r <= pres_cnt_r + 32'h1;
                    end
                    main_on_r <= want_main;
                    aux_on_r <= want_aux;
                    if (~main_on_r) begin
                        msu_r <= 32'h0;
                    end else if (msu_r < su_lim) begin
                        msu_r <= msu_r + 32'h1;
                    end
                    if (~aux_on_r) begin
                        asu_r <= 32'h0;
                    end else if (asu_r < su_lim) begin
                        asu_r <= asu_r + 32'h1;
                    end
                    moc_r <= (main_on_r & il_main) ? moc_r + 32'h1 : 32'h0;
                    aoc_r <= (aux_on_r & il_aux) ? aoc_r + 32'h1 : 32'h0;
                    if (ot) begin
                        ot_pend_r <= 1'b1;
                    end else begin
                        ot_pend_r <= 1'b0;
                    end
                    if (main_en) begin
                        mlow_r <= 32'h0;
                    end else if (mlow_r < P_CLR_CYC) begin
                        mlow_r <= mlow_r + 32'h1;
                    end
                    if (main_en | aux_en) begin
                        blow_r <= 32'h0;
                    end else if (blow_r < P_CLR_CYC) begin
                        blow_r <= blow_r + 32'h1;
                    end
                    if (fault_set) begin
                        mseen_r <= 1'b0;
                        bseen_r <= 1'b0;
                        rcnt_r <= 32'h0;
                    end else begin
                        if (mlow_r >= P_CLR_CYC) begin
                            mseen_r <= 1'b1;
                        end
                        if (blow_r >= P_CLR_CYC) begin
                            bseen_r <= 1'b1;
                        end
                        if ((main_flt_r | all_flt_r) & ~rdone) begin
                            rcnt_r <= rcnt_r + 32'h1;
                        end
                    end
                    if (mtrip) begin
                        main_flt_r <= 1'b1;
                    end else if (main_flt_r & rdone
                            & (auto_mode | mseen_r | bseen_r)) begin
                        main_flt_r <= 1'b0;
                    end
                    if (atrip | ot_done) begin
                        all_flt_r <= 1'b1;
                    end else if (all_flt_r & rdone
                            & (auto_mode | bseen_r)) begin
                        all_flt_r <= 1'b0;
                    end
                    if (~(main_on_r & aux_on_r & all_good)) begin
                        pg_cnt_r <= 32'h0;
                        pg_r <= 1'b0;
                    end else if (pg_cnt_r >= pgd_r) begin
                        pg_r <= 1'b1;
                    end else begin
                        pg_cnt_r <= pg_cnt_r + 32'h1;
                    end
                end
            end

            assign o_gate_12_en[s] = main_on_r;
            assign o_gate_33_en[s] = main_on_r;
            assign o_aux_rail_output_en[s] = aux_on_r;
            assign o_fault_n_oe[s] = main_flt_r | all_flt_r;
            assign o_power_good_n_oe[s] = pg_r;
            assign status[8*s +: 8] = {rdone, pres_ok_r, ot_pend_r,
                all_flt_r, main_flt_r, pg_r, aux_on_r, main_on_r};
        end
    endgenerate

    // Open-drain pins only ever pull low.
    reg [1:0] od_low_r;
    always @(posedge i_clk_sys) begin
        od_low_r <= 2'b00;
    end
    assign o_fault_n_o = od_low_r;
    assign o_power_good_n_o = od_low_r;

    genvar d;
    generate
        for (d = 0; d < 2; d = d + 1) begin : g_deb
            wire sw = sync2_r[24 + d];
            reg out_r;
            reg [31:0] hold_r;
            always @(posedge i_clk_sys) begin
                if (i_rst) begin
                    out_r <= 1'b0;
                    hold_r <= 32'h0;
                end else if (hold_r != 32'h0) begin
                    hold_r <= hold_r - 32'h1;
                end else if (sw != out_r) begin
                    out_r <= sw;
                    hold_r <= P_DEB_CYC - 1;
                end
            end
            assign o_switch_out[d] = out_r;
        end
    endgenerate

    assign o_s_axi_awready = awready_r;
    assign o_s_axi_wready = wready_r;
    assign o_s_axi_bvalid = bvalid_r;
    assign o_s_axi_bresp = bresp_r;
    assign o_s_axi_arready = arready_r;
    assign o_s_axi_rvalid = rvalid_r;
    assign o_s_axi_rresp = rresp_r;
    assign o_s_axi_rdata = rdata_r;

endmodule

// *** verif/dshpc_top_asserts.sv ***
// Concurrent checks on the hot-plug control; the lockout, rail pairing and open-drain checks cover both slots, the rest slot A.
`timescale 1ns/1ps
module dshpc_top_asserts #(
    parameter P_TMO_CYC = 10,
    parameter P_PGD_CYC = 30
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_uvlo_aux_ok,
    input wire i_uvlo_12_ok,
    input wire i_overtemp,
    input wire [1:0] i_force_on_n,
    input wire [1:0] i_card_present_n,
    input wire [1:0] i_ilim_12,
    input wire [1:0] i_ilim_33,
    input wire [1:0] i_ilim_aux,
    input wire [1:0] i_pg_12,
    input wire [1:0] i_pg_33,
    input wire [1:0] i_pg_aux,
    input wire [1:0] o_gate_12_en,
    input wire [1:0] o_gate_33_en,
    input wire [1:0] o_aux_rail_output_en,
    input wire [1:0] o_fault_n_o,
    input wire [1:0] o_fault_n_oe,
    input wire [1:0] o_power_good_n_o,
    input wire [1:0] o_power_good_n_oe,
    input wire [1:0] o_switch_out
);
    reg [15:0] lim_cnt;
    reg [15:0] pg_cnt;
    reg [15:0] flt_cnt;
    reg [3:0] ot_cnt;
    wire lim_a = i_ilim_12[0] | i_ilim_33[0] | i_ilim_aux[0];
    wire up_a = o_gate_12_en[0] & o_aux_rail_output_en[0] & i_pg_12[0]
        & i_pg_33[0] & i_pg_aux[0];

    // Pin-side counts include the input synchronisers, hence the slack.
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            lim_cnt <= 16'h0;
            pg_cnt <= 16'h0;
            flt_cnt <= 16'hffff;
            ot_cnt <= 4'h0;
        end else begin
            lim_cnt <= lim_a ? lim_cnt + 16'h1 : 16'h0;
            pg_cnt <= up_a ? pg_cnt + 16'h1 : 16'h0;
            flt_cnt <= $rose(o_fault_n_oe[0]) ? 16'h0 :
                flt_cnt + {15'h0, flt_cnt != 16'hffff};
            ot_cnt <= i_overtemp ? 4'hf : ot_cnt - {3'h0, ot_cnt != 4'h0};
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    pres_off_a: assert property (
        $rose(i_card_present_n[0]) && i_force_on_n[0] |-> ##[1:4]
        (!o_gate_12_en[0] && !o_aux_rail_output_en[0]))
        else $error("slot stayed on after card removal");
    lock_main_a: assert property (
        !i_uvlo_12_ok [*4] |-> o_gate_12_en == 2'h0)
        else $error("main gate on under lockout");
    lock_aux_a: assert property (
        !i_uvlo_aux_ok [*4] |-> (o_aux_rail_output_en | o_gate_12_en) == 2'h0)
        else $error("rail on under aux lockout");
    main_pair_a: assert property (
        o_gate_12_en == o_gate_33_en)
        else $error("main rails differ");
    drain_low_a: assert property (
        o_fault_n_o == 2'h0 && o_power_good_n_o == 2'h0)
        else $error("open drain pin driven high");
    pg_delay_a: assert property (
        $rose(o_power_good_n_oe[0]) |->
        pg_cnt >= P_PGD_CYC && pg_cnt <= P_PGD_CYC + 5)
        else $error("power good delay wrong");
    fault_time_a: assert property (
        $rose(o_fault_n_oe[0]) |-> lim_cnt >= P_TMO_CYC || ot_cnt != 4'h0)
        else $error("fault without full timeout");
    sw_hold_a: assert property (
        $changed(o_switch_out[0]) |=> $stable(o_switch_out[0]) [*8])
        else $error("switch output not held");
    restart_wait_a: assert property (
        $rose(o_gate_12_en[0]) |-> flt_cnt >= 64 * P_TMO_CYC - 2)
        else $error("restart before restart delay");

    flt_c: cover property ($rose(o_fault_n_oe[0]));
    pg_c: cover property ($rose(o_power_good_n_oe[0]));
    rst_c: cover property ($rose(o_gate_12_en[0]) && flt_cnt < 16'h1000);
endmodule

bind dshpc_top dshpc_top_asserts #(
    .P_TMO_CYC(P_TMO_CYC),
    .P_PGD_CYC(P_PGD_CYC)
) u_chk (.*);

// *** verif/dshpc_rail_model.sv ***
// Rail model: power-good flags rise after a ramp, drop at once on turn-off.
`timescale 1ns/1ps
module dshpc_rail_model #(
    parameter P_RAMP = 4
) (
    input wire i_clk_sys,
    input wire [1:0] i_main_en,
    input wire [1:0] i_aux_en,
    output wire [1:0] o_pg_main,
    output wire [1:0] o_pg_aux
);
    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1) begin : g_slot
            reg [7:0] m_r = 8'h0;
            reg [7:0] a_r = 8'h0;
            always @(posedge i_clk_sys) begin
                m_r <= i_main_en[s] ? m_r + {7'h0, m_r != P_RAMP} : 8'h0;
                a_r <= i_aux_en[s] ? a_r + {7'h0, a_r != P_RAMP} : 8'h0;
            end
            assign o_pg_main[s] = (m_r == P_RAMP);
            assign o_pg_aux[s] = (a_r == P_RAMP);
        end
    endgenerate
endmodule

// *** verif/dual_slot_hot_plug_control_test.sv ***
// Self-checking bench for the dual-slot hot-plug control.
`timescale 1ns/1ps
`include "dshpc_regs.vh"
module dual_slot_hot_plug_control_test;
    localparam TMO = 10;
    localparam PGD = 30;
    logic i_clk_sys = 1'h0;
    logic i_rst = 1'h1;
    logic [7:0] i_s_axi_awaddr = 8'h0, i_s_axi_araddr = 8'h0;
    logic [31:0] i_s_axi_wdata = 32'h0;
    logic [3:0] i_s_axi_wstrb = 4'h0;
    logic i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0;
    logic i_s_axi_bready = 1'h0, i_s_axi_arvalid = 1'h0;
    logic i_s_axi_rready = 1'h0, i_overtemp = 1'h0;
    logic i_uvlo_aux_ok = 1'h1, i_uvlo_12_ok = 1'h1, i_uvlo_33_ok = 1'h1;
    logic [1:0] i_main_enable = 2'h0, i_aux_rail_enable = 2'h0;
    logic [1:0] i_force_on_n = 2'h3, i_card_present_n = 2'h3;
    logic [1:0] i_ilim_12 = 2'h0, i_ilim_33 = 2'h0, i_ilim_aux = 2'h0;
    logic [1:0] i_switch_in = 2'h0;
    wire [1:0] i_pg_12, i_pg_33, i_pg_aux;
    wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
    wire o_s_axi_arready, o_s_axi_rvalid;
    wire [1:0] o_s_axi_bresp, o_s_axi_rresp, o_gate_12_en, o_gate_33_en;
    wire [1:0] o_aux_rail_output_en, o_fault_n_o, o_fault_n_oe;
    wire [1:0] o_power_good_n_o, o_power_good_n_oe, o_switch_out;
    wire [31:0] o_s_axi_rdata;
    int bad_count = 0;
    int cmp_count = 0;

    dshpc_top #(
        .P_DEB_CYC(20),
        .P_TMO_CYC(TMO),
        .P_PGD_CYC(PGD),
        .P_CLR_CYC(5)
    ) dut (.*);

    dshpc_rail_model u_rails (
        .i_clk_sys(i_clk_sys),
        .i_main_en(o_gate_12_en),
        .i_aux_en(o_aux_rail_output_en),
        .o_pg_main(i_pg_12),
        .o_pg_aux(i_pg_aux)
    );
    assign i_pg_33 = i_pg_12;

    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input string n, input [31:0] e, input [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask

    task rails(input string n, input [1:0] m, input [1:0] a);
        chk(n, {m, a}, {o_gate_12_en, o_aux_rail_output_en});
    endtask

    task bus_wait(input int k);
        if (k >= 50) begin
            bad_count++;
            $display("CHECK FAILED bus handshake expected 1 seen 0");
            give_verdict;
        end
    endtask

    task axw(input [7:0] a, input [31:0] d, input [1:0] r);
        int k;
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_wstrb <= 4'hf;
        i_s_axi_awvalid <= 1'h1;
        i_s_axi_wvalid <= 1'h1;
        i_s_axi_bready <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge i_clk_sys);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
            if (o_s_axi_bvalid) break;
        end
        i_s_axi_bready <= 1'h0;
        bus_wait(k);
        chk("bresp", r, o_s_axi_bresp);
        // One idle edge, so a following call never reassigns bready at once.
        cyc(1);
    endtask

    task axr(input [7:0] a, input [31:0] e, input [1:0] r);
        int k;
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'h1;
        i_s_axi_rready <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge i_clk_sys);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
            if (o_s_axi_rvalid) break;
        end
        i_s_axi_rready <= 1'h0;
        bus_wait(k);
        chk("rdata", e, o_s_axi_rdata);
        chk("rresp", r, o_s_axi_rresp);
        cyc(1);
    endtask

    // Causes a limit after startup, then removes it and checks the fault pin; the caller clears the fault.
    task trip(input int aux);
        cyc(25);
        if (aux) i_ilim_aux <= 2'h1;
        else i_ilim_12 <= 2'h1;
        cyc(16);
        i_ilim_12 <= 2'h0;
        i_ilim_aux <= 2'h0;
        chk("fault pin", 2'h1, o_fault_n_oe);
    endtask

    initial begin
        cyc(12);
        i_rst <= 1'h0;
        cyc(1);
        axr(`DSHPC_OFF_CTRL, 32'h0, `DSHPC_RESP_OKAY);
        axr(`DSHPC_OFF_FAULT_TMO, TMO, `DSHPC_RESP_OKAY);
        axr(`DSHPC_OFF_PG_DELAY, PGD, `DSHPC_RESP_OKAY);
        axr(8'h10, 32'h0, `DSHPC_RESP_SLVERR);
        axw(8'h10, 32'hffff_ffff, `DSHPC_RESP_SLVERR);
        axw(`DSHPC_OFF_CTRL, 32'hffff_ffff, `DSHPC_RESP_OKAY);
        axr(`DSHPC_OFF_CTRL, 32'h1, `DSHPC_RESP_OKAY);
        axw(`DSHPC_OFF_CTRL, 32'h0, `DSHPC_RESP_OKAY);
        i_switch_in <= 2'h3;
        cyc(5);
        chk("switch rise", 2'h3, o_switch_out);
        i_switch_in <= 2'h0;
        cyc(5);
        chk("switch held high", 2'h3, o_switch_out);
        cyc(20);
        chk("switch fall", 2'h0, o_switch_out);
        i_switch_in <= 2'h3;
        cyc(5);
        chk("switch held low", 2'h0, o_switch_out);
        cyc(20);
        chk("switch follows", 2'h3, o_switch_out);
        // Slot B stays empty while its enables are high.
        i_card_present_n <= 2'h2;
        i_main_enable <= 2'h3;
        i_aux_rail_enable <= 2'h3;
        cyc(15);
        rails("debounce", 2'h0, 2'h0);
        cyc(15);
        rails("powered", 2'h1, 2'h1);
        cyc(45);
        chk("power good", 2'h1, o_power_good_n_oe);
        // Slot A: main, aux, power good and presence qualified; B empty.
        axr(`DSHPC_OFF_STATUS, 32'h0000_0047, `DSHPC_RESP_OKAY);
        i_aux_rail_enable <= 2'h0;
        cyc(5);
        rails("aux off", 2'h1, 2'h0);
        chk("power good off", 2'h0, o_power_good_n_oe);
        i_main_enable <= 2'h0;
        i_aux_rail_enable <= 2'h3;
        cyc(5);
        rails("main off", 2'h0, 2'h1);
        i_main_enable <= 2'h3;
        for (int l = 0; l < 3; l++) begin
            {i_uvlo_aux_ok, i_uvlo_12_ok, i_uvlo_33_ok} <= ~(3'h1 << l);
            cyc(5);
            rails("lockout", 2'h0, {1'h0, l != 2});
            {i_uvlo_aux_ok, i_uvlo_12_ok, i_uvlo_33_ok} <= 3'h7;
            cyc(5);
            rails("lockout gone", 2'h1, 2'h1);
        end
        i_card_present_n <= 2'h3;
        cyc(5);
        rails("removed", 2'h0, 2'h0);
        i_main_enable <= 2'h0;
        i_aux_rail_enable <= 2'h0;
        i_force_on_n <= 2'h2;
        cyc(5);
        rails("forced", 2'h1, 2'h1);
        i_force_on_n <= 2'h3;
        i_card_present_n <= 2'h2;
        i_main_enable <= 2'h3;
        i_aux_rail_enable <= 2'h3;
        cyc(30);
        cyc(25);
        i_ilim_33 <= 2'h1;
        cyc(8);
        i_ilim_33 <= 2'h0;
        cyc(5);
        rails("short limit", 2'h1, 2'h1);
        trip(0);
        rails("main fault", 2'h0, 2'h1);
        i_main_enable <= 2'h2;
        cyc(10);
        i_main_enable <= 2'h3;
        cyc(5);
        rails("early clear", 2'h0, 2'h1);
        cyc(650);
        i_main_enable <= 2'h2;
        cyc(10);
        i_main_enable <= 2'h3;
        cyc(5);
        rails("main cleared", 2'h1, 2'h1);
        chk("fault released", 2'h0, o_fault_n_oe);
        trip(1);
        rails("aux fault", 2'h0, 2'h0);
        cyc(650);
        i_main_enable <= 2'h2;
        cyc(10);
        i_main_enable <= 2'h3;
        cyc(5);
        rails("main pulse only", 2'h0, 2'h0);
        {i_main_enable, i_aux_rail_enable} <= 4'ha;
        cyc(10);
        {i_main_enable, i_aux_rail_enable} <= 4'hf;
        cyc(5);
        rails("all cleared", 2'h1, 2'h1);
        axw(`DSHPC_OFF_CTRL, 32'h1, `DSHPC_RESP_OKAY);
        trip(0);
        cyc(650);
        rails("auto restart", 2'h1, 2'h1);
        chk("auto release", 2'h0, o_fault_n_oe);
        axw(`DSHPC_OFF_CTRL, 32'h0, `DSHPC_RESP_OKAY);
        i_overtemp <= 1'h1;
        cyc(5);
        rails("overtemp", 2'h0, 2'h0);
        chk("overtemp pending", 2'h0, o_fault_n_oe);
        i_overtemp <= 1'h0;
        cyc(6);
        chk("overtemp fault", 2'h3, o_fault_n_oe);
        give_verdict;
    end
endmodule
